// ### logic/ntsc_ctrl.sv
/*
 * no-turnaround synchronous burst sram controller, top level.
 * assumes the memory runs on clk (forwarded on mem_clk) and that the
 * bench resolves the data wire from mem_data_oe.
 */
// Added by the designer: the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ntsc_ctrl #(
  parameter int address_width_param  = ntsc_pkg::ADDR_W_DEF,
  parameter int data_width_param     = ntsc_pkg::DATA_W_DEF,
  parameter int byte_lane_count_param = ntsc_pkg::LANES_DEF,
  parameter bit FLOWTHROUGH          = ntsc_pkg::MODE_PIPELINED
) (
  // clock and reset
  input  wire logic                             clk,
  input  wire logic                             rst,
  // user request side
  input  wire logic                             user_request,
  input  wire logic                             user_read_not_write,
  input  wire logic                             user_advance_or_load,
  input  wire logic [address_width_param-1:0]   user_address,
  input  wire logic [data_width_param-1:0]      user_write_data,
  input  wire logic [byte_lane_count_param-1:0] user_byte_mask,
  // user answer side
  output logic      [data_width_param-1:0]      user_read_data,
  output logic                                  user_read_valid,
  // memory command side
  output logic                                  mem_clk,
  output logic                                  mem_chip_enable_low,
  output logic                                  mem_read_write_select,
  output logic                                  mem_advance_or_load,
  output logic      [address_width_param-1:0]   mem_address_bus,
  output logic [byte_lane_count_param-1:0] mem_byte_write_enables_low,
  // memory data bus
  input  wire logic [data_width_param-1:0]      mem_data_in,
  output logic      [data_width_param-1:0]      mem_data_out,
  output logic                                  mem_data_oe
);

  localparam int AW = address_width_param;
  localparam int DW = data_width_param;
  localparam int BW = byte_lane_count_param;
  // delay between user stage and write data register
  localparam int WR_DLY = ntsc_pkg::MEM_LAT_PIPE - int'(FLOWTHROUGH);
  // read tracking ends one stage early: the answer word is the sync flop, or dq_hold in flow-through
  localparam int RD_PIPE = ntsc_pkg::USER_RD_LAT - 2;
  // cycles from user write to data seen on the bus at a sampling edge
  localparam int WR_SEEN = ntsc_pkg::CMD_STAGES + WR_DLY;

  // ==========================================================================
  // state
  typedef struct packed {
    logic               stg_req;
    logic               stg_rd;
    logic               stg_adv;
    logic [AW-1:0]      stg_addr;
    logic [BW-1:0]      stg_mask;
    logic [DW-1:0]      stg_wdata;
    logic               cmd_cs_n;
    logic               cmd_rw;
    logic               cmd_adv;
    logic [AW-1:0]      cmd_addr;
    logic [BW-1:0]      cmd_bw_n;
    logic               wr_oe;
    logic [DW-1:0]      wr_data;
    logic [RD_PIPE-1:0] rd_pipe;
    logic [DW-1:0]      dq_hold;
    logic               rd_valid;
  } ntsc_ctrl_s;

  ntsc_ctrl_s st_q;
  ntsc_ctrl_s st_d;

  logic [DW:0]   wr_late;
  logic [DW-1:0] dq_synced;

  // ==========================================================================
  // write data alignment; pipelined waits one cycle longer than flow-through
  ntsc_delay_line #(
    .WIDTH (DW + 1),
    .DEPTH (WR_DLY)
  ) u_wr_dly (
    .clk  (clk),
    .rst  (rst),
    .din  ({st_q.stg_req & ~st_q.stg_rd, st_q.stg_wdata}),
    .dout (wr_late)
  );

  // ==========================================================================
  // read capture; bus comes from the pins, so two flops before use
  ntsc_sync2 #(
    .WIDTH (DW)
  ) u_rd_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (mem_data_in),
    .dout (dq_synced)
  );

  // ==========================================================================
  // next state
  always_comb begin
    st_d = st_q;
    // user stage: one register so inputs meet timing
    st_d.stg_req  = user_request;
    st_d.stg_rd   = user_read_not_write;
    st_d.stg_adv  = user_advance_or_load;
    st_d.stg_addr = user_address;
    st_d.stg_mask = user_byte_mask;
    st_d.stg_wdata = user_write_data;
    // command register; an idle cycle is a deselected read
    st_d.cmd_cs_n = ~st_q.stg_req;
    st_d.cmd_rw   = st_q.stg_req ? st_q.stg_rd
                                 : ntsc_pkg::RW_READ;
    st_d.cmd_adv  = st_q.stg_adv;
    st_d.cmd_addr = st_q.stg_addr;
    // any mix of loads and advances passes through unchanged
    st_d.cmd_bw_n = (st_q.stg_req && !st_q.stg_rd) ? ~st_q.stg_mask
                                                   : {BW{1'b1}};
    // write data and enable leave together
    st_d.wr_oe    = wr_late[DW];
    st_d.wr_data  = wr_late[DW-1:0];
    // read tracking; no idle cycles inserted between reads and writes
    st_d.rd_pipe  = {st_q.rd_pipe[RD_PIPE-2:0],
                     st_q.stg_req & st_q.stg_rd};
    // flow-through data is on the bus a cycle earlier, so hold it once
    st_d.dq_hold  = dq_synced;
    st_d.rd_valid = st_q.rd_pipe[RD_PIPE-1];
  end

  // ==========================================================================
  // registers; reset leaves the memory reading with no enable low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q          <= '0;
      st_q.cmd_cs_n <= ntsc_pkg::CS_IDLE_LOW_N;
      st_q.cmd_rw   <= ntsc_pkg::RW_READ;
      st_q.cmd_adv  <= ntsc_pkg::ADV_LOAD;
      st_q.cmd_bw_n <= '1;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // outputs, all straight from flops except mem_clk, which is clk forwarded
  assign mem_clk                    = clk;
  assign mem_chip_enable_low        = st_q.cmd_cs_n;
  assign mem_read_write_select      = st_q.cmd_rw;
  assign mem_advance_or_load        = st_q.cmd_adv;
  assign mem_address_bus            = st_q.cmd_addr;
  assign mem_byte_write_enables_low = st_q.cmd_bw_n;
  assign mem_data_out               = st_q.wr_data;
  assign mem_data_oe                = st_q.wr_oe;
  // answer word straight from a flop; valid only beside user_read_valid
  assign user_read_data             = FLOWTHROUGH ? st_q.dq_hold
                                                  : dq_synced;
  assign user_read_valid            = st_q.rd_valid;

  // ==========================================================================
  // checks
  property p_rd_latency;
    @(posedge clk) disable iff (rst)
    user_request && user_read_not_write |-> ##6 user_read_valid;
  endproperty
  a_rd_latency: assert property (p_rd_latency)
    else $error("read answer not six cycles after request");

  property p_valid_cause;
    @(posedge clk) disable iff (rst)
    user_read_valid |-> $past(user_request && user_read_not_write, 6);
  endproperty
  a_valid_cause: assert property (p_valid_cause)
    else $error("read valid without a read six cycles before");

  property p_wr_data;
    @(posedge clk) disable iff (rst)
    user_request && !user_read_not_write |-> ##WR_SEEN
      (mem_data_oe && mem_data_out == $past(user_write_data, WR_SEEN));
  endproperty
  a_wr_data: assert property (p_wr_data)
    else $error("write data not on bus at the required edge");

  property p_oe_only_write;
    @(posedge clk) disable iff (rst)
    mem_data_oe |-> $past(user_request && !user_read_not_write, WR_SEEN);
  endproperty
  a_oe_only_write: assert property (p_oe_only_write)
    else $error("bus driven outside a write data cycle");

  property p_oe_vs_cmd;
    @(posedge clk) disable iff (rst)
    mem_data_oe |-> $past(!mem_read_write_select && !mem_chip_enable_low,
                          WR_DLY);
  endproperty
  a_oe_vs_cmd: assert property (p_oe_vs_cmd)
    else $error("bus driven without matching write command");

  property p_rw_select;
    @(posedge clk) disable iff (rst)
    user_request |-> ##2
      (mem_read_write_select == $past(user_read_not_write, 2));
  endproperty
  a_rw_select: assert property (p_rw_select)
    else $error("read/write select does not follow request");

  property p_byte_enables;
    @(posedge clk) disable iff (rst)
    user_request && !user_read_not_write |-> ##2
      (mem_byte_write_enables_low == ~$past(user_byte_mask, 2));
  endproperty
  a_byte_enables: assert property (p_byte_enables)
    else $error("byte enables not the inverted mask");

  property p_no_enable_read;
    @(posedge clk) disable iff (rst)
    !(user_request && !user_read_not_write) |-> ##2
      (&mem_byte_write_enables_low);
  endproperty
  a_no_enable_read: assert property (p_no_enable_read)
    else $error("byte enable low outside a write");

  property p_addr_adv;
    @(posedge clk) disable iff (rst)
    user_request |-> ##2 (mem_address_bus == $past(user_address, 2)
      && mem_advance_or_load == $past(user_advance_or_load, 2));
  endproperty
  a_addr_adv: assert property (p_addr_adv)
    else $error("address or advance/load not forwarded");

  property p_turnaround;
    @(posedge clk) disable iff (rst)
    (user_request && user_read_not_write)
      ##1 (user_request && !user_read_not_write)
      |-> ##1 mem_read_write_select ##1 !mem_read_write_select;
  endproperty
  a_turnaround: assert property (p_turnaround)
    else $error("idle cycle inserted between read and write");

  property p_reset_safe;
    @(posedge clk)
    rst |-> (!mem_data_oe && (&mem_byte_write_enables_low)
             && mem_read_write_select);
  endproperty
  a_reset_safe: assert property (p_reset_safe)
    else $error("memory not held safe during reset");

endmodule : ntsc_ctrl
`default_nettype wire

// ### logic/ntsc_delay_line.sv
/*
 * fixed-length register delay line.
 * assumes depth of at least one; every stage loads on every edge.
 */
`timescale 1ns/1ps
`default_nettype none
module ntsc_delay_line #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // data
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] stage;
  } ntsc_dly_s;

  ntsc_dly_s st_q;
  ntsc_dly_s st_d;

  // ==========================================================================
  // shift
  always_comb begin
    st_d = st_q;
    st_d.stage[0] = din;
    for (int i = 1; i < DEPTH; i++) begin
      st_d.stage[i] = st_q.stage[i-1];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.stage[DEPTH-1];

endmodule : ntsc_delay_line
`default_nettype wire

// ### logic/ntsc_sync2.sv
/*
 * two-flop synchroniser for the data bus pins.
 * assumes the pins settle within one clock; first flop feeds only the second.
 */
`timescale 1ns/1ps
`default_nettype none
module ntsc_sync2 #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // data
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } ntsc_sync_s;

  ntsc_sync_s st_q;
  ntsc_sync_s st_d;

  always_comb begin
    st_d = st_q;
    st_d.first  = din;
    st_d.second = st_q.first;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.second;

endmodule : ntsc_sync2
`default_nettype wire

// ### pkg/ntsc_pkg.sv
/*
 * constants shared by the no-turnaround synchronous sram controller.
 * assumes one system clock shared with the memory, rising edge only.
 */
package ntsc_pkg;

  // ==========================================================================
  // widths and modes
  localparam int ADDR_W_DEF     = 18;
  localparam int DATA_W_DEF     = 32;
  localparam int LANES_DEF      = 4;
  localparam bit MODE_PIPELINED = 1'b0;
  localparam bit MODE_FLOWTHRU  = 1'b1;

  // ==========================================================================
  // latencies in clock cycles
  localparam int CMD_STAGES     = 2;
  localparam int MEM_LAT_PIPE   = 2;
  localparam int MEM_LAT_FLOW   = 1;
  localparam int USER_RD_LAT    = 6;
  localparam int SYNC_STAGES    = 2;

  // ==========================================================================
  // values of memory-side controls; all but RW_WRITE are loaded at reset
  localparam bit RW_READ        = 1'b1;
  localparam bit RW_WRITE       = 1'b0;
  localparam bit ADV_LOAD       = 1'b0;
  localparam bit CS_IDLE_LOW_N  = 1'b1;

endpackage : ntsc_pkg

// ### testbench/ntsc_sram_model.sv
/*
 * behavioural synchronous burst sram with no turnaround cycles.
 * assumes the forwarded controller clock and an 8-bit slice of the address.
 */
`timescale 1ns/1ps
`default_nettype none
module ntsc_sram_model #(
  parameter int DW   = 32,
  parameter int BW   = 4,
  parameter bit FLOW = 1'b0
) (
  // clock
  input  wire logic          clk,
  // command
  input  wire logic          cs_n,
  input  wire logic          rw,
  input  wire logic          adv,
  input  wire logic [7:0]    addr,
  input  wire logic [BW-1:0] bw_n,
  // data bus
  input  wire logic [DW-1:0] dq_in,
  output logic      [DW-1:0] dq_out,
  output logic               dq_oe
);
  localparam int LW = DW / BW;
  logic [DW-1:0] mem [0:255];
  logic [7:0]    ba, ra, wa0, wa1;
  logic [BW-1:0] wb0, wb1;
  logic          rv;
  logic [1:0]    wv;

  initial begin
    foreach (mem[i]) mem[i] = '0;
    {ba, rv, wv, dq_oe, dq_out} = '0;
  end

  // ==========================================================================
  // command decode, read pipe and write pipe
  always @(posedge clk) begin : seq
    logic [7:0] a;
    logic [7:0] w;
    a = adv ? {ba[7:2], ba[1:0] + 2'h1} : addr;
    w = FLOW ? wa0 : wa1;
    if (!cs_n) ba <= a;
    rv <= !cs_n && rw;
    ra <= a;
    if (FLOW ? (!cs_n && rw) : rv) begin
      dq_oe  <= 1'b1;
      dq_out <= mem[FLOW ? a : ra];
    end else begin
      // released: toggle so a stale sample can never pass for data
      dq_oe  <= 1'b0;
      dq_out <= ~dq_out;
    end
    wv         <= {wv[0], !cs_n && !rw};
    {wa1, wa0} <= {wa0, a};
    {wb1, wb0} <= {wb0, bw_n};
    if (FLOW ? wv[0] : wv[1])
      for (int l = 0; l < BW; l++)
        if (!(FLOW ? wb0[l] : wb1[l]))
          mem[w][l*LW +: LW] <= dq_in[l*LW +: LW];
  end
endmodule : ntsc_sram_model
`default_nettype wire

// ### testbench/test_ntsc_ctrl.sv
/*
 * bench: one controller per latency mode, each beside a memory model.
 * assumes both controllers see the same user stimulus.
 */
`timescale 1ns/1ps
`default_nettype none
`define ntsc_chk(what, exp, got) \
  begin \
    n_chk++; \
    if ((got) !== (exp)) begin \
      n_err++; \
      $display("MISMATCH %s exp %0h got %0h", what, exp, got); \
    end \
  end
// ============================================================================
// controller, memory model and scoreboard for one mode
module ntsc_env #(
  parameter bit FLOW = 1'b0
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // user request
  input  wire logic        req,
  input  wire logic        rd,
  input  wire logic        adv,
  input  wire logic [17:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  mask,
  // score
  output var int           n_err,
  output var int           n_chk
);
  localparam int BW = 4;
  localparam int LW = 8;
  localparam int WL = FLOW ? ntsc_pkg::MEM_LAT_FLOW : ntsc_pkg::MEM_LAT_PIPE;
  typedef struct {
    int tk; logic rd; logic adv; logic [17:0] a; logic [31:0] d;
    logic [3:0] m;
  } ntsc_op_s;
  ntsc_op_s    cq[$], wq[$], rq[$], o;
  logic [31:0] shadow [0:255], rdata, dout, mdq, din;
  logic [17:0] maddr;
  logic [3:0]  bwn;
  logic [7:0]  ba;
  logic        csn, rws, advo, doe, moe, rvalid, mclk;
  int          cyc;

  assign din = doe ? dout : mdq;

  ntsc_ctrl #(.FLOWTHROUGH(FLOW)) i_dut (
    .clk(clk), .rst(rst), .user_request(req), .user_read_not_write(rd),
    .user_advance_or_load(adv), .user_address(addr),
    .user_write_data(wdata), .user_byte_mask(mask),
    .user_read_data(rdata), .user_read_valid(rvalid), .mem_clk(mclk),
    .mem_chip_enable_low(csn), .mem_read_write_select(rws),
    .mem_advance_or_load(advo), .mem_address_bus(maddr),
    .mem_byte_write_enables_low(bwn), .mem_data_in(din),
    .mem_data_out(dout), .mem_data_oe(doe));

  ntsc_sram_model #(.FLOW(FLOW)) i_mem (
    .clk(mclk), .cs_n(csn), .rw(rws), .adv(advo), .addr(maddr[7:0]),
    .bw_n(bwn), .dq_in(din), .dq_out(mdq), .dq_oe(moe));

  initial begin
    {n_err, n_chk, cyc, ba} = '0;
    foreach (shadow[i]) shadow[i] = '0;
  end

  always @(posedge clk) begin : score
    if (rst) begin
      `ntsc_chk("reset oe", 1'b0, doe)
      `ntsc_chk("reset bw", 4'hF, bwn)
      `ntsc_chk("reset rw", 1'b1, rws)
    end else begin
      `ntsc_chk("contention", 1'b0, doe & moe)
      if (cq.size() > 0 && cq[0].tk + 2 == cyc) begin
        o = cq.pop_front();
        `ntsc_chk("cs", 1'b0, csn)
        `ntsc_chk("rw", o.rd, rws)
        `ntsc_chk("adv", o.adv, advo)
        if (!o.adv) `ntsc_chk("addr", o.a, maddr)
        `ntsc_chk("bw", o.rd ? 4'hF : ~o.m, bwn)
      end else begin
        `ntsc_chk("idle cs", 1'b1, csn)
        `ntsc_chk("idle bw", 4'hF, bwn)
      end
      if (wq.size() > 0 && wq[0].tk + 2 + WL == cyc) begin
        o = wq.pop_front();
        `ntsc_chk("oe", 1'b1, doe)
        `ntsc_chk("wdata", o.d, dout)
      end else `ntsc_chk("oe idle", 1'b0, doe)
      if (rq.size() > 0 && rq[0].tk + 6 == cyc) begin
        o = rq.pop_front();
        `ntsc_chk("valid", 1'b1, rvalid)
        `ntsc_chk("rdata", o.d, rdata)
      end else `ntsc_chk("valid idle", 1'b0, rvalid)
      if (req) begin
        ba = adv ? {ba[7:2], ba[1:0] + 2'h1} : addr[7:0];
        o = '{cyc, rd, adv, addr, wdata, mask};
        for (int l = 0; l < BW; l++)
          if (!rd && mask[l]) shadow[ba][l*LW +: LW] = wdata[l*LW +: LW];
        o.d = rd ? shadow[ba] : wdata;
        cq.push_back(o);
        if (rd) rq.push_back(o);
        else wq.push_back(o);
      end
    end
    cyc++;
  end
endmodule : ntsc_env
// ============================================================================
// top: clock, reset, shared stimulus and verdict
module test_ntsc_ctrl;
  logic        clk, rst, req, rd, adv;
  logic [17:0] addr;
  logic [31:0] wdata;
  logic [3:0]  mask;
  int          n_mismatch, check_count, tcount;
  int          e_err [2];
  int          e_chk [2];

  ntsc_env #(.FLOW(1'b0)) i_pipe (.clk(clk), .rst(rst), .req(req), .rd(rd),
    .adv(adv), .addr(addr), .wdata(wdata), .mask(mask),
    .n_err(e_err[0]), .n_chk(e_chk[0]));
  ntsc_env #(.FLOW(1'b1)) i_flow (.clk(clk), .rst(rst), .req(req), .rd(rd),
    .adv(adv), .addr(addr), .wdata(wdata), .mask(mask),
    .n_err(e_err[1]), .n_chk(e_chk[1]));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic op(input logic r, input logic v, input logic [17:0] a,
                    input logic [31:0] d, input logic [3:0] m);
    @(posedge clk);
    req   <= 1'b1;
    rd    <= r;
    adv   <= v;
    addr  <= a;
    wdata <= d;
    mask  <= m;
  endtask : op

  task automatic fin(input string name);
    repeat (10) @(posedge clk) req <= 1'b0;
    $display("test %s done", name);
  endtask : fin

  task automatic stop_test;
    n_mismatch  = n_mismatch + e_err[0] + e_err[1];
    check_count = e_chk[0] + e_chk[1];
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  // a hang counts against the run; about 94 cycles are expected
  always @(posedge clk) begin
    tcount <= tcount + 1;
    if (tcount == 1000) begin
      n_mismatch++;
      stop_test();
    end
  end

  initial begin
    {rst, rd} = 2'b01;
    {req, adv, addr, wdata, mask} = '0;
    {n_mismatch, check_count, tcount} = '0;
    // a clean rising edge on rst so the asynchronous reset is seen
    #1 rst = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    fin("reset");
    for (int i = 0; i < 8; i++)
      op(1'b0, 1'b0, 18'h20 + 18'(i), 32'hA5C30F00 + i, 4'(15 - i));
    fin("masked writes");
    op(1'b0, 1'b0, 18'h43, 32'h11223344, 4'hF);
    for (int i = 0; i < 3; i++)
      op(1'b0, 1'b1, 18'h0, 32'h0BADF00D + i, 4'hF);
    fin("burst write");
    for (int i = 0; i < 8; i++) op(1'b1, 1'b0, 18'h20 + 18'(i), '0, '0);
    op(1'b1, 1'b0, 18'h43, '0, '0);
    for (int i = 0; i < 3; i++) op(1'b1, 1'b1, 18'h0, '0, '0);
    fin("reads");
    for (int i = 0; i < 4; i++) begin
      op(1'b0, 1'b0, 18'h30 + 18'(i), 32'h5A000000 + i, 4'hF);
      op(1'b1, 1'b0, 18'h20 + 18'(i), '0, '0);
    end
    for (int i = 0; i < 4; i++) op(1'b1, 1'b0, 18'h30 + 18'(i), '0, '0);
    fin("turnaround");
    stop_test();
  end
endmodule : test_ntsc_ctrl
`default_nettype wire
